/* hdl/rsm_pkg.sv */
// Function
// RULE1 - With the autocal field at zero the synthesizer is calibrated only on the calibrate strobe.
// RULE2 - With the autocal field at one a calibration runs on every exit from idle toward receive, transmit or synth-on.
// RULE3 - With the autocal field at two a calibration runs on every return from receive or transmit to idle.
// RULE4 - With the autocal field at three only every fourth return from receive or transmit to idle calibrates.
// RULE5 - Software should pick autocal setting three for periodic wake-and-listen use to save current.
// RULE6 - After the crystal is stable, chip ready low waits for the programmed number of ripple counter expiries.
// RULE7 - Power-up wait codes 0 to 3 give 1, 16, 64 and 256 expiries, with code 1 after reset.
// RULE8 - Software should pick power-up wait code 2 when the digital regulator is off in sleep.
// RULE9 - The pin control enable bit lets the radio state pins steer the radio beside the strobes; clear after reset.
// RULE10 - The crystal keep-on bit keeps the crystal running in sleep; clear after reset.
package rsm_pkg;
  localparam logic [7:0] RSM_ADDR_CONFIG_ZERO = 8'h18;
  localparam int RSM_AUTOCAL_LSB = 4;
  localparam int RSM_PWAIT_LSB = 2;
  localparam int RSM_PIN_CTRL_BIT = 1;
  localparam int RSM_XKEEP_BIT = 0;
  localparam logic [1:0] RSM_AUTOCAL_RESET = 2'h0;
  localparam logic [1:0] RSM_PWAIT_RESET = 2'h1;
  localparam logic [7:0] RSM_REG_RESET = 8'h04;
  localparam logic [7:0] RSM_REG_WMASK = 8'h3F;
  localparam int RSM_RIPPLE_BITS = 6;
  localparam logic [1:0] RSM_CAL_EVERY = 2'h3;
  typedef enum logic [3:0] {
    RSM_ST_IDLE = 4'h1,
    RSM_ST_RX = 4'h2,
    RSM_ST_TX = 4'h4,
    RSM_ST_FSON = 4'h8
  } rsm_radio_st_t;
  typedef enum logic [2:0] {
    RSM_PU_OFF = 3'h1,
    RSM_PU_WAIT = 3'h2,
    RSM_PU_READY = 3'h4
  } rsm_pu_st_t;
  // Expiry count for a power-up wait code
  function automatic logic [8:0] rsm_expiries(input logic [1:0] code);
    unique case (code)
      2'h0: rsm_expiries = 9'h001;
      2'h1: rsm_expiries = 9'h010;
      2'h2: rsm_expiries = 9'h040;
      2'h3: rsm_expiries = 9'h100;
    endcase
  endfunction
endpackage

/* hdl/rsm_powerup.sv */
`timescale 1ns/1ns
// Chip-ready timer: six-bit ripple counter expiries after crystal stable
module rsm_powerup
  import rsm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic crystal_stable,
  input wire logic [1:0] powerup_wait_count,
  output logic chip_ready_n
);
  typedef struct packed {
    rsm_pu_st_t st;
    logic [RSM_RIPPLE_BITS-1:0] ripple;
    logic [8:0] expired;
    logic ready_n;
  } rsm_pu_state_t;
  rsm_pu_state_t cur, next_cur;

  // Count expiries; crystal loss restarts the wait
  always_comb begin
    next_cur = cur;
    unique case (cur.st)
      RSM_PU_OFF: begin
        next_cur.ready_n = 1'b1;
        next_cur.ripple = '0;
        next_cur.expired = '0;
        if (crystal_stable) begin
          next_cur.st = RSM_PU_WAIT;
        end
      end
      RSM_PU_WAIT: begin
        next_cur.ripple = cur.ripple + 1'b1;
        if (&cur.ripple) begin
          next_cur.expired = cur.expired + 9'h001;
          if (cur.expired + 9'h001 >= rsm_expiries(powerup_wait_count)) begin // [RULE6] [RULE7]
            next_cur.st = RSM_PU_READY;
            next_cur.ready_n = 1'b0;
          end
        end
        // Loss wins over a final expiry in the same cycle
        if (!crystal_stable) begin
          next_cur.st = RSM_PU_OFF;
          next_cur.ready_n = 1'b1; // [RULE6]
        end
      end
      RSM_PU_READY: begin
        if (!crystal_stable) begin
          next_cur.st = RSM_PU_OFF;
          next_cur.ready_n = 1'b1;
        end
      end
      default: next_cur.st = RSM_PU_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '{st: RSM_PU_OFF, ripple: '0, expired: '0, ready_n: 1'b1};
    end else begin
      cur <= next_cur;
    end
  end

  assign chip_ready_n = cur.ready_n;

  // Ready never falls while crystal unstable
  property p_ready_needs_xtal;
    @(posedge sys_clk) disable iff (!arst_n) $fell(cur.ready_n) |-> $past(crystal_stable);
  endproperty
  a_ready_needs_xtal: assert property (p_ready_needs_xtal) else $error("ready without crystal"); // [RULE6]

  // Code 0: exactly one expiry of 64 cycles
  property p_wait_code0;
    @(posedge sys_clk) disable iff (!arst_n)
      (cur.st == RSM_PU_OFF && crystal_stable && powerup_wait_count == 2'h0) ##1
      (crystal_stable && powerup_wait_count == 2'h0) [*8] |-> ##57 $fell(cur.ready_n) || !crystal_stable;
  endproperty
  a_wait_code0: assert property (p_wait_code0) else $error("code 0 wait wrong"); // [RULE7]

  c_ready: cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(cur.ready_n));
endmodule

/* hdl/rsm_config_zero.sv */
`timescale 1ns/1ns
// Radio state machine config register zero with autocal, power-up and sleep control
module rsm_config_zero
  import rsm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic calibrate_strobe,
  input wire logic [3:0] radio_state,
  input wire logic pin_rx_req,
  input wire logic pin_tx_req,
  input wire logic pin_idle_req,
  input wire logic sleep_active,
  input wire logic crystal_stable,
  output logic synth_cal_start,
  output logic pin_go_rx,
  output logic pin_go_tx,
  output logic pin_go_idle,
  output logic crystal_enable,
  output logic chip_ready_n
);
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic [3:0] prev_state;
    logic [1:0] idle_returns;
    logic cal;
    logic go_rx;
    logic go_tx;
    logic go_idle;
    logic xtal_en;
  } rsm_state_t;
  rsm_state_t cur, next_cur;

  logic [1:0] synth_autocal_select;
  logic [1:0] powerup_wait_count;
  logic pin_ctrl_en;
  logic crystal_keep_on_sleep;
  logic leave_idle;
  logic back_to_idle;

  // Field views of the register
  assign synth_autocal_select = cur.cfg[RSM_AUTOCAL_LSB +: 2];
  assign powerup_wait_count = cur.cfg[RSM_PWAIT_LSB +: 2];
  assign pin_ctrl_en = cur.cfg[RSM_PIN_CTRL_BIT];
  assign crystal_keep_on_sleep = cur.cfg[RSM_XKEEP_BIT];

  // Transition detection on the one-hot radio state
  assign leave_idle = (cur.prev_state == RSM_ST_IDLE) &&
                      (radio_state == RSM_ST_RX || radio_state == RSM_ST_TX || radio_state == RSM_ST_FSON);
  assign back_to_idle = (cur.prev_state == RSM_ST_RX || cur.prev_state == RSM_ST_TX) &&
                        (radio_state == RSM_ST_IDLE);

  always_comb begin
    next_cur = cur;
    next_cur.prev_state = radio_state;
    // Bits 7:6 unused, read zero
    if (reg_wr && reg_addr == RSM_ADDR_CONFIG_ZERO) begin
      next_cur.cfg = reg_wdata & RSM_REG_WMASK;
    end
    next_cur.rdata = (reg_rd && reg_addr == RSM_ADDR_CONFIG_ZERO) ? cur.cfg : 8'h00;
    // Manual strobe always calibrates; the mode adds automatic triggers
    next_cur.cal = calibrate_strobe; // [RULE1]
    unique case (synth_autocal_select)
      2'h0: ;
      2'h1: if (leave_idle) next_cur.cal = 1'b1; // [RULE2]
      2'h2: if (back_to_idle) next_cur.cal = 1'b1; // [RULE3]
      2'h3: begin
        if (back_to_idle) begin
          next_cur.idle_returns = cur.idle_returns + 2'h1; // [RULE4]
          if (cur.idle_returns == RSM_CAL_EVERY) next_cur.cal = 1'b1; // [RULE4]
        end
      end
    endcase
    // Pin requests pass only when enabled; strobes are handled elsewhere
    next_cur.go_rx = pin_ctrl_en && pin_rx_req; // [RULE9]
    next_cur.go_tx = pin_ctrl_en && pin_tx_req; // [RULE9]
    next_cur.go_idle = pin_ctrl_en && pin_idle_req; // [RULE9]
    next_cur.xtal_en = !sleep_active || crystal_keep_on_sleep; // [RULE10]
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '{cfg: RSM_REG_RESET, rdata: 8'h00, prev_state: RSM_ST_IDLE, idle_returns: 2'h0,
               cal: 1'b0, go_rx: 1'b0, go_tx: 1'b0, go_idle: 1'b0, xtal_en: 1'b1};
    end else begin
      cur <= next_cur;
    end
  end

  rsm_powerup u_powerup (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .crystal_stable(crystal_stable),
    .powerup_wait_count(powerup_wait_count),
    .chip_ready_n(chip_ready_n)
  );

  assign reg_rdata = cur.rdata;
  assign synth_cal_start = cur.cal;
  assign pin_go_rx = cur.go_rx;
  assign pin_go_tx = cur.go_tx;
  assign pin_go_idle = cur.go_idle;
  assign crystal_enable = cur.xtal_en;

  // Mode 0: only the strobe may calibrate
  property p_mode0_only_strobe;
    @(posedge sys_clk) disable iff (!arst_n)
      synth_cal_start && $past(synth_autocal_select) == 2'h0 |-> $past(calibrate_strobe);
  endproperty
  a_mode0_only_strobe: assert property (p_mode0_only_strobe) else $error("autocal in mode 0"); // [RULE1]

  // Mode 1: exit from idle calibrates
  property p_mode1_leave;
    @(posedge sys_clk) disable iff (!arst_n) synth_autocal_select == 2'h1 && leave_idle |=> synth_cal_start;
  endproperty
  a_mode1_leave: assert property (p_mode1_leave) else $error("no cal leaving idle"); // [RULE2]

  // Mode 2: return to idle calibrates
  property p_mode2_return;
    @(posedge sys_clk) disable iff (!arst_n) synth_autocal_select == 2'h2 && back_to_idle |=> synth_cal_start;
  endproperty
  a_mode2_return: assert property (p_mode2_return) else $error("no cal on idle return"); // [RULE3]

  // Mode 3: only every fourth return calibrates
  property p_mode3_fourth;
    @(posedge sys_clk) disable iff (!arst_n)
      synth_autocal_select == 2'h3 && back_to_idle && !calibrate_strobe |=>
      synth_cal_start == ($past(cur.idle_returns) == RSM_CAL_EVERY);
  endproperty
  a_mode3_fourth: assert property (p_mode3_fourth) else $error("mode 3 cal count wrong"); // [RULE4]

  // Pin requests blocked while disabled
  property p_pin_gate;
    @(posedge sys_clk) disable iff (!arst_n) pin_go_rx || pin_go_tx || pin_go_idle |-> $past(pin_ctrl_en);
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin control while disabled"); // [RULE9]

  // Crystal in sleep follows the keep-on bit
  property p_xtal_sleep;
    @(posedge sys_clk) disable iff (!arst_n) sleep_active ##1 sleep_active |-> crystal_enable == $past(crystal_keep_on_sleep);
  endproperty
  a_xtal_sleep: assert property (p_xtal_sleep) else $error("crystal sleep control wrong"); // [RULE10]

  // Field values right after reset
  property p_reset_fields;
    @(posedge sys_clk) $rose(arst_n) |-> powerup_wait_count == RSM_PWAIT_RESET && synth_autocal_select == RSM_AUTOCAL_RESET;
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("reset field values wrong"); // [RULE7]

  // Readback of the config byte; top bits zero
  property p_read_back;
    @(posedge sys_clk) disable iff (!arst_n)
      reg_rd && reg_addr == RSM_ADDR_CONFIG_ZERO && !reg_wr |=> reg_rdata == $past(cur.cfg) && reg_rdata[7:6] == 2'h0;
  endproperty
  a_read_back: assert property (p_read_back) else $error("readback wrong"); // [RULE7]

  // Manual strobe works in every mode
  property p_strobe_any_mode;
    @(posedge sys_clk) disable iff (!arst_n) calibrate_strobe |=> synth_cal_start;
  endproperty
  a_strobe_any_mode: assert property (p_strobe_any_mode) else $error("strobe did not calibrate"); // [RULE1]

  // Mode 1: no calibration without strobe or idle exit
  property p_mode1_quiet;
    @(posedge sys_clk) disable iff (!arst_n)
      synth_autocal_select == 2'h1 && !calibrate_strobe && !leave_idle |=> !synth_cal_start;
  endproperty
  a_mode1_quiet: assert property (p_mode1_quiet) else $error("stray cal in mode 1"); // [RULE2]

  // Mode 2: no calibration without strobe or idle return
  property p_mode2_quiet;
    @(posedge sys_clk) disable iff (!arst_n)
      synth_autocal_select == 2'h2 && !calibrate_strobe && !back_to_idle |=> !synth_cal_start;
  endproperty
  a_mode2_quiet: assert property (p_mode2_quiet) else $error("stray cal in mode 2"); // [RULE3]

  // Mode 3: no calibration without strobe or idle return
  property p_mode3_quiet;
    @(posedge sys_clk) disable iff (!arst_n)
      synth_autocal_select == 2'h3 && !calibrate_strobe && !back_to_idle |=> !synth_cal_start;
  endproperty
  a_mode3_quiet: assert property (p_mode3_quiet) else $error("stray cal in mode 3"); // [RULE4]

  // Mode 3: each return to idle advances the count
  property p_mode3_count;
    @(posedge sys_clk) disable iff (!arst_n)
      synth_autocal_select == 2'h3 && back_to_idle |=> cur.idle_returns == $past(cur.idle_returns) + 2'h1;
  endproperty
  a_mode3_count: assert property (p_mode3_count) else $error("idle return count wrong"); // [RULE4]

  // Count holds outside mode 3, so a later switch resumes it
  property p_count_hold;
    @(posedge sys_clk) disable iff (!arst_n) synth_autocal_select != 2'h3 |=> $stable(cur.idle_returns);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("idle count moved outside mode 3"); // [RULE4]

  // Write keeps only the six low bits
  property p_cfg_write;
    @(posedge sys_clk) disable iff (!arst_n) reg_wr && reg_addr == RSM_ADDR_CONFIG_ZERO |=>
      cur.cfg[7:6] == 2'h0 && cur.cfg[5:0] == $past(reg_wdata[5:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write wrong"); // [RULE7]

  // Config changes only through its own address
  property p_cfg_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      !(reg_wr && reg_addr == RSM_ADDR_CONFIG_ZERO) |=> $stable(cur.cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write"); // [RULE7]

  // Read data returns to zero when not read
  property p_read_idle;
    @(posedge sys_clk) disable iff (!arst_n)
      !(reg_rd && reg_addr == RSM_ADDR_CONFIG_ZERO) |=> reg_rdata == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not cleared"); // [RULE7]

  // Enabled pin requests pass one cycle later
  property p_pin_pass;
    @(posedge sys_clk) disable iff (!arst_n)
      pin_ctrl_en |=> {pin_go_rx, pin_go_tx, pin_go_idle} == $past({pin_rx_req, pin_tx_req, pin_idle_req});
  endproperty
  a_pin_pass: assert property (p_pin_pass) else $error("pin request not passed"); // [RULE9]

  // Crystal always on while awake
  property p_xtal_awake;
    @(posedge sys_clk) disable iff (!arst_n) !sleep_active |=> crystal_enable;
  endproperty
  a_xtal_awake: assert property (p_xtal_awake) else $error("crystal off while awake"); // [RULE10]

  // Loss of crystal raises chip ready at once, even at a final expiry
  property p_ready_drop;
    @(posedge sys_clk) disable iff (!arst_n) !crystal_stable |=> chip_ready_n;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready held without crystal"); // [RULE6]

  c_cal_mode1: cover property (@(posedge sys_clk) disable iff (!arst_n) synth_autocal_select == 2'h1 ##1 synth_cal_start);
  c_cal_mode2: cover property (@(posedge sys_clk) disable iff (!arst_n) synth_autocal_select == 2'h2 ##1 synth_cal_start);
  c_cal_mode3: cover property (@(posedge sys_clk) disable iff (!arst_n) synth_autocal_select == 2'h3 ##1 synth_cal_start);
  c_pin_rx: cover property (@(posedge sys_clk) disable iff (!arst_n) pin_go_rx);
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import rsm_pkg::*;
  logic sys_clk, arst_n, reg_wr, reg_rd, calibrate_strobe, sleep_active, crystal_stable;
  logic pin_rx_req, pin_tx_req, pin_idle_req, synth_cal_start, pin_go_rx, pin_go_tx, pin_go_idle;
  logic crystal_enable, chip_ready_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [3:0] radio_state;
  int fails, cmp_count, n;
  int unsigned exp_tab[4] = '{1, 16, 64, 256};
  rsm_config_zero dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .calibrate_strobe(calibrate_strobe), .radio_state(radio_state), .pin_rx_req(pin_rx_req),
    .pin_tx_req(pin_tx_req), .pin_idle_req(pin_idle_req), .sleep_active(sleep_active),
    .crystal_stable(crystal_stable), .synth_cal_start(synth_cal_start), .pin_go_rx(pin_go_rx),
    .pin_go_tx(pin_go_tx), .pin_go_idle(pin_go_idle), .crystal_enable(crystal_enable),
    .chip_ready_n(chip_ready_n));
  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Inputs move on the falling edge, away from the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk); reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge sys_clk); reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk); reg_rd = 1'b1; reg_addr = a;
    @(negedge sys_clk); reg_rd = 1'b0; d = reg_rdata;
  endtask
  // Counts calibration pulses in a short window; catches doubled pulses too
  task automatic go(input logic [3:0] s, input int expn);
    @(negedge sys_clk); radio_state = s; n = 0;
    repeat (4) begin @(negedge sys_clk); if (synth_cal_start === 1'b1) n++; end
    chk(n[15:0], expn[15:0]);
  endtask
  task automatic t_regs();
    rd(8'h18, rv); chk(rv, 8'h04);
    @(negedge sys_clk); chk(reg_rdata, 8'h00);
    wr(8'h18, 8'hFF); rd(8'h18, rv); chk(rv, 8'h3F);
    wr(8'h17, 8'h00); rd(8'h18, rv); chk(rv, 8'h3F);
    rd(8'h17, rv); chk(rv, 8'h00);
    wr(8'h18, 8'h04);
  endtask
  task automatic t_cal();
    // Mode three first, while its transition counter is still at zero
    wr(8'h18, 8'h34);
    for (int i = 1; i <= 8; i++) begin
      go((i % 2) ? RSM_ST_RX : RSM_ST_TX, 0);
      go(RSM_ST_IDLE, (i % 4 == 0) ? 1 : 0);
    end
    wr(8'h18, 8'h04);
    go(RSM_ST_RX, 0); go(RSM_ST_IDLE, 0);
    // One-cycle strobe; the pulse stands until the next edge
    @(negedge sys_clk); calibrate_strobe = 1'b1;
    @(negedge sys_clk); calibrate_strobe = 1'b0;
    chk(synth_cal_start, 1'b1);
    go(RSM_ST_IDLE, 0);
    wr(8'h18, 8'h14);
    go(RSM_ST_RX, 1); go(RSM_ST_IDLE, 0); go(RSM_ST_TX, 1);
    go(RSM_ST_IDLE, 0); go(RSM_ST_FSON, 1); go(RSM_ST_IDLE, 0);
    wr(8'h18, 8'h24);
    go(RSM_ST_RX, 0); go(RSM_ST_IDLE, 1); go(RSM_ST_TX, 0); go(RSM_ST_IDLE, 1);
  endtask
  task automatic t_pins_xtal();
    @(negedge sys_clk); {pin_rx_req, pin_tx_req, pin_idle_req} = 3'h7; sleep_active = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({pin_go_rx, pin_go_tx, pin_go_idle}, 3'h0);
    chk(crystal_enable, 1'b0);
    wr(8'h18, 8'h07); repeat (2) @(negedge sys_clk);
    chk({pin_go_rx, pin_go_tx, pin_go_idle}, 3'h7);
    chk(crystal_enable, 1'b1);
    {pin_rx_req, pin_tx_req, pin_idle_req} = 3'h0; sleep_active = 1'b0;
    wr(8'h18, 8'h04);
  endtask
  // Wait is timed from the stable edge; a few cycles of pipeline slack allowed
  task automatic t_ready(input int code);
    wr(8'h18, 8'(code << RSM_PWAIT_LSB));
    @(negedge sys_clk); crystal_stable = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(chip_ready_n, 1'b1);
    crystal_stable = 1'b1; n = 0;
    while (chip_ready_n !== 1'b0 && n < 20000) begin @(negedge sys_clk); n++; end
    chk(n >= exp_tab[code] * 64 && n <= exp_tab[code] * 64 + 3, 1'b1);
  endtask
  // Watchdog sized from the longest wait of 256 expiries
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  initial begin
    {arst_n, reg_wr, reg_rd, calibrate_strobe, sleep_active, crystal_stable} = 6'h0;
    {pin_rx_req, pin_tx_req, pin_idle_req} = 3'h0;
    reg_addr = 8'h00; reg_wdata = 8'h00; radio_state = RSM_ST_IDLE;
    fails = 0; cmp_count = 0;
    repeat (16) @(negedge sys_clk);
    arst_n = 1'b1;
    t_regs();
    t_cal();
    t_pins_xtal();
    for (int c = 0; c < 4; c++) t_ready(c);
    wrap_up();
  end
endmodule
